// [spd_serial_dma.sv]
// Serial ping-pong DMA channel pair with register port and byte memory port
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Two buffers per direction, automatic switch over
// RULE_02 - Moves bytes FIFO to memory without processor
// RULE_03 - Signals only on whole buffer completion
// RULE_04 - Buffer is idle, pending or active
// RULE_05 - Software resets channel before buffer setup
// RULE_06 - Start and inclusive end address per buffer
// RULE_07 - Software keeps buffers in on-chip RAM
// RULE_08 - Unload sets flag; enabled flag raises interrupt
// RULE_09 - Software starts by setting load bits
// RULE_10 - End address writable while pending or active
// RULE_11 - Count is offset of next byte, advances
// RULE_12 - One transmit count, two receive counts
// RULE_13 - Counts kept until reload or reset
// RULE_14 - Receive count writable while loaded
// RULE_15 - Receive count write loads idle buffer
// RULE_16 - Unload when start plus count exceeds end
// RULE_17 - Comparison continuous; software writes unload early
// RULE_18 - Both loaded together: A active, B pending
// RULE_19 - Load bit reads status; zero write ignored
// RULE_20 - Channel reset bit per direction, self-clearing
// RULE_21 - Channel reset idles buffers, clears counts
module spd_serial_dma (
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  input  wire logic [spd_pkg::BUS_AW-1:0]      reg_addr,
  input  wire logic [spd_pkg::BUS_DW-1:0]      reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [spd_pkg::BUS_DW-1:0]      reg_rdata,
  output logic      [spd_pkg::ADDR_W-1:0]      mem_addr,
  output logic                                 mem_re,
  output logic                                 mem_we,
  output logic      [spd_pkg::BYTE_W-1:0]      mem_wdata,
  input  wire logic [spd_pkg::BYTE_W-1:0]      mem_rdata,
  input  wire logic                            tx_fifo_free,
  output logic                                 tx_fifo_push,
  output logic      [spd_pkg::BYTE_W-1:0]      tx_fifo_data,
  input  wire logic                            rx_fifo_valid,
  input  wire logic [spd_pkg::BYTE_W-1:0]      rx_fifo_data,
  output logic                                 rx_fifo_pop,
  output logic                                 serial_top_irq
);
  import spd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    spd_st_t                      st;
    logic [1:0][ADDR_W-1:0]       tx_beg;
    logic [1:0][ADDR_W-1:0]       tx_end;
    logic [CNT_W-1:0]             tx_cnt;
    logic [1:0]                   tx_ld;
    logic                         tx_sel;
    logic [1:0][ADDR_W-1:0]       rx_beg;
    logic [1:0][ADDR_W-1:0]       rx_end;
    logic [1:0][CNT_W-1:0]        rx_cnt;
    logic [1:0]                   rx_ld;
    logic                         rx_sel;
    logic [FLG_W-1:0]             flags;
    logic [FLG_W-1:0]             en;
    logic [BUS_DW-1:0]            rdata;
    logic [ADDR_W-1:0]            mem_addr;
    logic                         mem_re;
    logic                         mem_we;
    logic [BYTE_W-1:0]            mem_wdata;
    logic [BYTE_W-1:0]            tx_data;
    logic                         tx_push;
  } spd_state_t;

  spd_state_t       q;
  spd_state_t       d;
  logic [1:0]       tx_done;
  logic [1:0]       rx_done;
  logic [1:0]       tx_unl;
  logic [1:0]       rx_unl;
  logic             ctrl_wr;
  logic             tx_rst;
  logic             rx_rst;
  logic [1:0]       tx_ldw;
  logic [1:0]       rx_ldw;
  logic [1:0]       rx_ldset;
  logic             rx_go;

  // ----------------------------------------------------------------
  // Unload comparators
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    spd_unload_cmp u_tx_cmp (
      .beg_addr (q.tx_beg[i]),
      .cnt      (q.tx_cnt),
      .end_addr (q.tx_end[i]),
      .done     (tx_done[i])
    );
    spd_unload_cmp u_rx_cmp (
      .beg_addr (q.rx_beg[i]),
      .cnt      (q.rx_cnt[i]),
      .end_addr (q.rx_end[i]),
      .done     (rx_done[i])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.tx_push  = 1'b0;
    d.mem_re   = 1'b0;
    d.mem_we   = 1'b0;
    d.rdata    = RD_ZERO;
    rx_go      = 1'b0;
    rx_ldset   = 2'b00;
    ctrl_wr    = reg_wr && (reg_addr == OFF_CTRL);
    tx_rst     = ctrl_wr && reg_wdata[CTRL_TX_RST];
    rx_rst     = ctrl_wr && reg_wdata[CTRL_RX_RST];
    // Zero bits in a control write load nothing
    tx_ldw     = ctrl_wr ? reg_wdata[CTRL_TX_LDB:CTRL_TX_LDA] : 2'b00; // RULE_19
    rx_ldw     = ctrl_wr ? reg_wdata[CTRL_RX_LDB:CTRL_RX_LDA] : 2'b00;
    // Only the active transmit buffer owns the shared count
    for (int i = 0; i < 2; i++) begin
      tx_unl[i] = q.tx_ld[i] && (q.tx_sel == i[0]) && tx_done[i]; // RULE_16 RULE_17
      rx_unl[i] = q.rx_ld[i] && rx_done[i]; // RULE_16 RULE_17
    end

    // Byte engine: transmit first, receive when transmit has nothing to do
    unique case (q.st)
      SPD_IDLE: begin
        if (q.tx_ld[q.tx_sel] && !tx_unl[q.tx_sel] && tx_fifo_free && !tx_rst) begin // RULE_02
          d.mem_re   = 1'b1;
          d.mem_addr = q.tx_beg[q.tx_sel] + q.tx_cnt; // RULE_11
          d.st       = SPD_TX_WAIT;
        end else if (q.rx_ld[q.rx_sel] && !rx_unl[q.rx_sel] && rx_fifo_valid
                     && !rx_rst) begin // RULE_02
          rx_go                = 1'b1;
          d.mem_we             = 1'b1;
          d.mem_addr           = q.rx_beg[q.rx_sel] + q.rx_cnt[q.rx_sel];
          d.mem_wdata          = rx_fifo_data;
          d.rx_cnt[q.rx_sel]   = q.rx_cnt[q.rx_sel] + CNT_ONE; // RULE_11 RULE_12
        end
      end
      SPD_TX_WAIT: begin
        d.st = SPD_TX_CAP;
      end
      SPD_TX_CAP: begin
        d.tx_data = mem_rdata;
        d.tx_push = 1'b1;
        d.tx_cnt  = q.tx_cnt + CNT_ONE; // RULE_11 RULE_12
        d.st      = SPD_IDLE;
      end
    endcase

    // Address registers stay writable in any buffer state
    if (reg_wr) begin
      case (reg_addr)
        OFF_TX_BEG_A: d.tx_beg[0] = reg_wdata[ADDR_W-1:0]; // RULE_06
        OFF_TX_END_A: d.tx_end[0] = reg_wdata[ADDR_W-1:0]; // RULE_06 RULE_10
        OFF_TX_BEG_B: d.tx_beg[1] = reg_wdata[ADDR_W-1:0];
        OFF_TX_END_B: d.tx_end[1] = reg_wdata[ADDR_W-1:0]; // RULE_10
        OFF_RX_BEG_A: d.rx_beg[0] = reg_wdata[ADDR_W-1:0];
        OFF_RX_END_A: d.rx_end[0] = reg_wdata[ADDR_W-1:0]; // RULE_10
        OFF_RX_BEG_B: d.rx_beg[1] = reg_wdata[ADDR_W-1:0];
        OFF_RX_END_B: d.rx_end[1] = reg_wdata[ADDR_W-1:0]; // RULE_10
        OFF_EN:       d.en        = reg_wdata[FLG_W-1:0];
        default: ;
      endcase
    end

    // Transmit buffers: unload, switch, reset, load
    d.tx_ld = q.tx_ld & ~tx_unl; // RULE_04
    if (!d.tx_ld[q.tx_sel] && d.tx_ld[~q.tx_sel]) begin
      d.tx_sel = ~q.tx_sel; // RULE_01
      d.tx_cnt = CNT_ZERO;
    end
    if (tx_rst) begin
      d.tx_ld   = 2'b00; // RULE_20 RULE_21
      d.tx_sel  = BUF_A;
      d.tx_cnt  = CNT_ZERO;
      d.st      = SPD_IDLE;
      d.tx_push = 1'b0;
      d.mem_re  = 1'b0;
    end
    if (tx_ldw != 2'b00) begin
      if (d.tx_ld == 2'b00) begin
        d.tx_sel = tx_ldw[0] ? BUF_A : BUF_B; // RULE_18
        d.tx_cnt = CNT_ZERO; // RULE_13
      end
      d.tx_ld = d.tx_ld | tx_ldw;
    end

    // Receive buffers: unload, switch, reset, load by bit or by count
    d.rx_ld = q.rx_ld & ~rx_unl; // RULE_04
    if (!d.rx_ld[q.rx_sel] && d.rx_ld[~q.rx_sel]) begin
      d.rx_sel = ~q.rx_sel; // RULE_01
    end
    if (rx_rst) begin
      d.rx_ld  = 2'b00; // RULE_20 RULE_21
      d.rx_sel = BUF_A;
      d.rx_cnt = '0;
      d.mem_we = 1'b0;
      rx_go    = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (rx_ldw[i]) begin
        d.rx_cnt[i] = CNT_ZERO; // RULE_13
      end
    end
    if (reg_wr && (reg_addr == OFF_RX_CNT_A)) begin
      d.rx_cnt[0] = reg_wdata[CNT_W-1:0]; // RULE_14
      rx_ldset[0] = 1'b1; // RULE_15
    end
    if (reg_wr && (reg_addr == OFF_RX_CNT_B)) begin
      d.rx_cnt[1] = reg_wdata[CNT_W-1:0]; // RULE_14
      rx_ldset[1] = 1'b1; // RULE_15
    end
    rx_ldset = rx_ldset | rx_ldw;
    if (rx_ldset != 2'b00) begin
      if (d.rx_ld == 2'b00) begin
        d.rx_sel = rx_ldset[0] ? BUF_A : BUF_B; // RULE_18
      end
      d.rx_ld = d.rx_ld | rx_ldset;
    end

    // Sticky unload flags; a new unload beats a clear in the same cycle
    d.flags = q.flags;
    if (reg_wr && (reg_addr == OFF_FLAG)) begin
      d.flags = q.flags & ~reg_wdata[FLG_W-1:0];
    end
    d.flags = d.flags | {tx_unl, rx_unl}; // RULE_08 RULE_03

    // Read data for one cycle only; reset bits always read zero
    if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL:     d.rdata = {28'h0000000, q.tx_ld, q.rx_ld}; // RULE_19 RULE_20
        OFF_TX_BEG_A: d.rdata = 32'(q.tx_beg[0]);
        OFF_TX_END_A: d.rdata = 32'(q.tx_end[0]);
        OFF_TX_BEG_B: d.rdata = 32'(q.tx_beg[1]);
        OFF_TX_END_B: d.rdata = 32'(q.tx_end[1]);
        OFF_TX_CNT:   d.rdata = 32'(q.tx_cnt);
        OFF_RX_BEG_A: d.rdata = 32'(q.rx_beg[0]);
        OFF_RX_END_A: d.rdata = 32'(q.rx_end[0]);
        OFF_RX_BEG_B: d.rdata = 32'(q.rx_beg[1]);
        OFF_RX_END_B: d.rdata = 32'(q.rx_end[1]);
        OFF_RX_CNT_A: d.rdata = 32'(q.rx_cnt[0]);
        OFF_RX_CNT_B: d.rdata = 32'(q.rx_cnt[1]);
        OFF_STAT: d.rdata = {28'h0000000,
                             q.tx_ld[1] && (q.tx_sel == BUF_B),
                             q.tx_ld[0] && (q.tx_sel == BUF_A),
                             q.rx_ld[1] && (q.rx_sel == BUF_B),
                             q.rx_ld[0] && (q.rx_sel == BUF_A)}; // RULE_04
        OFF_FLAG:     d.rdata = 32'(q.flags);
        OFF_EN:       d.rdata = 32'(q.en);
        default:      d.rdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata      = q.rdata;
  assign mem_addr       = q.mem_addr;
  assign mem_re         = q.mem_re;
  assign mem_we         = q.mem_we;
  assign mem_wdata      = q.mem_wdata;
  assign tx_fifo_push   = q.tx_push;
  assign tx_fifo_data   = q.tx_data;
  assign rx_fifo_pop    = rx_go;
  // Level output: stays up until software clears the flag or the enable
  assign serial_top_irq = |(q.flags & q.en); // RULE_08 RULE_03

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_both_load;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_ldw == 2'b11 && q.tx_ld == 2'b00 && !tx_rst)
        |=> (q.tx_ld == 2'b11 && q.tx_sel == BUF_A);
  endproperty
  a_both_load: assert property (p_both_load) // RULE_18
    else $error("both buffers loaded but A not active");

  property p_tx_cnt_clear;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_ldw != 2'b00 && q.tx_ld == 2'b00) |=> (q.tx_cnt == CNT_ZERO);
  endproperty
  a_tx_cnt_clear: assert property (p_tx_cnt_clear) // RULE_13
    else $error("transmit count not cleared on load");

  property p_tx_unload;
    @(posedge core_clk) disable iff (!rst_n)
      (q.tx_ld[0] && q.tx_sel == BUF_A && tx_done[0] && !tx_ldw[0])
        |=> (!q.tx_ld[0] && q.flags[CTRL_TX_LDA]);
  endproperty
  a_tx_unload: assert property (p_tx_unload) // RULE_16
    else $error("transmit buffer A not unloaded");

  property p_rx_flag;
    @(posedge core_clk) disable iff (!rst_n)
      (q.rx_ld[1] && rx_done[1]) |=> q.flags[CTRL_RX_LDB] ##1 q.flags[CTRL_RX_LDB];
  endproperty
  a_rx_flag: assert property (p_rx_flag) // RULE_08
    else $error("receive B unload flag missing");

  property p_chan_reset;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_rst && tx_ldw == 2'b00) |=> (q.tx_ld == 2'b00 && q.tx_cnt == CNT_ZERO
                                      && q.st == SPD_IDLE);
  endproperty
  a_chan_reset: assert property (p_chan_reset) // RULE_21
    else $error("transmit channel reset incomplete");

  property p_ctrl_read;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_CTRL)
        |=> (reg_rdata == {28'h0000000, $past(q.tx_ld), $past(q.rx_ld)});
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) // RULE_19
    else $error("control read does not show load status");

  property p_no_spurious_load;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_ldw == 2'b00) |=> ((q.tx_ld & ~$past(q.tx_ld)) == 2'b00);
  endproperty
  a_no_spurious_load: assert property (p_no_spurious_load) // RULE_19
    else $error("transmit buffer loaded without a load bit");

  property p_tx_step;
    @(posedge core_clk) disable iff (!rst_n)
      (q.st == SPD_TX_CAP && !tx_rst && tx_ldw == 2'b00 && q.tx_ld[q.tx_sel])
        |=> (tx_fifo_push && tx_fifo_data == $past(mem_rdata)
             && q.tx_cnt == $past(q.tx_cnt) + CNT_ONE);
  endproperty
  a_tx_step: assert property (p_tx_step) // RULE_11
    else $error("transmit byte not pushed or count not advanced");

  property p_rx_cnt_load;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFF_RX_CNT_A && !q.rx_ld[0])
        |=> (q.rx_ld[0] && q.rx_cnt[0] == $past(reg_wdata[CNT_W-1:0]));
  endproperty
  a_rx_cnt_load: assert property (p_rx_cnt_load) // RULE_15
    else $error("receive count write did not load buffer A");

endmodule

// [spd_pkg.sv]
// Shared constants and types for the serial ping-pong DMA channel
package spd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam int ADDR_W = 16;
  localparam int CNT_W  = 16;
  localparam int BYTE_W = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [BUS_AW-1:0] OFF_CTRL     = 8'h00;
  localparam logic [BUS_AW-1:0] OFF_TX_BEG_A = 8'h04;
  localparam logic [BUS_AW-1:0] OFF_TX_END_A = 8'h08;
  localparam logic [BUS_AW-1:0] OFF_TX_BEG_B = 8'h0C;
  localparam logic [BUS_AW-1:0] OFF_TX_END_B = 8'h10;
  localparam logic [BUS_AW-1:0] OFF_TX_CNT   = 8'h14;
  localparam logic [BUS_AW-1:0] OFF_RX_BEG_A = 8'h18;
  localparam logic [BUS_AW-1:0] OFF_RX_END_A = 8'h1C;
  localparam logic [BUS_AW-1:0] OFF_RX_BEG_B = 8'h20;
  localparam logic [BUS_AW-1:0] OFF_RX_END_B = 8'h24;
  localparam logic [BUS_AW-1:0] OFF_RX_CNT_A = 8'h28;
  localparam logic [BUS_AW-1:0] OFF_RX_CNT_B = 8'h2C;
  localparam logic [BUS_AW-1:0] OFF_STAT     = 8'h30;
  localparam logic [BUS_AW-1:0] OFF_FLAG     = 8'h34;
  localparam logic [BUS_AW-1:0] OFF_EN       = 8'h38;

  // ----------------------------------------------------------------
  // Control bits; status, flag and enable share the low four positions
  // ----------------------------------------------------------------
  localparam int CTRL_RX_LDA = 0;
  localparam int CTRL_RX_LDB = 1;
  localparam int CTRL_TX_LDA = 2;
  localparam int CTRL_TX_LDB = 3;
  localparam int CTRL_RX_RST = 4;
  localparam int CTRL_TX_RST = 5;
  localparam int FLG_W       = 4;

  localparam logic       BUF_A   = 1'b0;
  localparam logic       BUF_B   = 1'b1;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
  localparam logic [BUS_DW-1:0] RD_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPD_IDLE,
    SPD_TX_WAIT,
    SPD_TX_CAP
  } spd_st_t;

endpackage

// [spd_unload_cmp.sv]
// Unload comparator for one buffer: start plus count beyond inclusive end
`timescale 1ns/1ps
module spd_unload_cmp (
  input  wire logic [spd_pkg::ADDR_W-1:0] beg_addr,
  input  wire logic [spd_pkg::CNT_W-1:0]  cnt,
  input  wire logic [spd_pkg::ADDR_W-1:0] end_addr,
  output logic                            done
);
  import spd_pkg::*;

  // One extra bit so a wrap past the top of memory still counts as beyond
  logic [ADDR_W:0] sum;

  assign sum  = {1'b0, beg_addr} + {1'b0, cnt};
  assign done = sum > {1'b0, end_addr};

endmodule

// [spd_far_model.sv]
// Far side model: byte RAM plus serial transmit and receive FIFOs
`timescale 1ns/1ps
module spd_far_model (
  input  wire logic       core_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic       mem_re,
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] mem_rdata,
  input  wire logic       tx_stall,
  output logic            tx_fifo_free,
  input  wire logic       tx_fifo_push,
  input  wire logic [7:0] tx_fifo_data,
  output logic            rx_fifo_valid,
  output logic      [7:0] rx_fifo_data,
  input  wire logic       rx_fifo_pop
);
  logic [7:0] ram [256];
  logic [7:0] rx_q [$];
  logic [7:0] tx_q [$];

  // ----------------------------------------------------------------
  // On-chip RAM; only the low address byte is decoded
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) begin
      ram[i] = i[7:0] ^ 8'hA5;
    end
    mem_rdata = 8'h00;
    rx_fifo_valid = 1'b0;
    rx_fifo_data = 8'h00;
  end
  always @(posedge core_clk) begin
    if (mem_we) begin
      ram[mem_addr[7:0]] <= mem_wdata;
    end
    // Read data stands one cycle, then scrambles so stale bytes never pass
    mem_rdata <= mem_re ? ram[mem_addr[7:0]] : ~mem_rdata;
  end

  // ----------------------------------------------------------------
  // Serial FIFOs
  // ----------------------------------------------------------------
  assign tx_fifo_free = !tx_stall;
  always @(posedge core_clk) begin
    if (tx_fifo_push) begin
      tx_q.push_back(tx_fifo_data);
    end
    if (rx_fifo_pop && rx_q.size() != 0) begin
      void'(rx_q.pop_front());
    end
    rx_fifo_valid <= rx_q.size() != 0;
    rx_fifo_data <= (rx_q.size() != 0) ? rx_q[0] : ~rx_fifo_data;
  end
endmodule

// [serial_pingpong_dma_test.sv]
// Self-checking testbench for the serial ping-pong DMA channel pair
`timescale 1ns/1ps
module serial_pingpong_dma_test;
  import spd_pkg::*;
  logic        core_clk, rst_n, reg_wr, reg_rd, tx_stall;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] mem_addr;
  logic        mem_re, mem_we, tx_fifo_free, tx_fifo_push;
  logic        rx_fifo_valid, rx_fifo_pop, serial_top_irq;
  logic [7:0]  mem_wdata, mem_rdata, tx_fifo_data, rx_fifo_data;
  int          errors, check_count;

  spd_serial_dma dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .tx_fifo_free(tx_fifo_free), .tx_fifo_push(tx_fifo_push),
    .tx_fifo_data(tx_fifo_data), .rx_fifo_valid(rx_fifo_valid),
    .rx_fifo_data(rx_fifo_data), .rx_fifo_pop(rx_fifo_pop),
    .serial_top_irq(serial_top_irq));
  spd_far_model far (.core_clk(core_clk), .mem_addr(mem_addr), .mem_re(mem_re),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .tx_stall(tx_stall), .tx_fifo_free(tx_fifo_free), .tx_fifo_push(tx_fifo_push),
    .tx_fifo_data(tx_fifo_data), .rx_fifo_valid(rx_fifo_valid),
    .rx_fifo_data(rx_fifo_data), .rx_fifo_pop(rx_fifo_pop));

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  // Polls by register reads so the bus stays busy during transfers
  task automatic wait_flag(input logic [3:0] m);
    logic [31:0] d;
    d = 32'h0;
    for (int n = 0; n < 300 && (d[3:0] & m) !== m; n++) rd(OFF_FLAG, d);
    chk("flag", {28'h0, m}, d & {28'h0, m});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc("ctrl", OFF_CTRL, 32'h0);
    rdc("stat", OFF_STAT, 32'h0);
    rdc("txcnt", OFF_TX_CNT, 32'h0);
    rdc("unmapped", 8'h3C, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_tx;
    wr(OFF_CTRL, 32'h20);
    wr(OFF_TX_BEG_A, 32'h10); wr(OFF_TX_END_A, 32'h12);
    wr(OFF_TX_BEG_B, 32'h20); wr(OFF_TX_END_B, 32'h20);
    rdc("txenda", OFF_TX_END_A, 32'h12);
    rdc("txbegb", OFF_TX_BEG_B, 32'h20);
    wr(OFF_CTRL, 32'h0C);
    rdc("stat", OFF_STAT, 32'h4);
    rdc("ctrl", OFF_CTRL, 32'h0C);
    repeat (20) @(posedge core_clk);
    chk("stalled", 0, far.tx_q.size());
    tx_stall <= 1'b0;
    wait_flag(4'hC);
    chk("txlen", 4, far.tx_q.size());
    for (int i = 0; i < 4; i++) begin
      chk("txbyte", {24'h0, 8'hA5 ^ (i < 3 ? 8'h10 + i[7:0] : 8'h20)}, far.tx_q[i]);
    end
    rdc("txcnt", OFF_TX_CNT, 32'h1);
    rdc("ctrl", OFF_CTRL, 32'h0);
    $display("test tx done");
  endtask
  task automatic t_rx;
    wr(OFF_CTRL, 32'h10);
    wr(OFF_RX_BEG_A, 32'h40); wr(OFF_RX_END_A, 32'h41);
    wr(OFF_RX_BEG_B, 32'h50); wr(OFF_RX_END_B, 32'h51);
    rdc("rxbegb", OFF_RX_BEG_B, 32'h50);
    rdc("rxendb", OFF_RX_END_B, 32'h51);
    wr(OFF_CTRL, 32'h03);
    for (int i = 1; i < 5; i++) far.rx_q.push_back(8'h11 * i[7:0]);
    wait_flag(4'h3);
    chk("ram40", 8'h11, far.ram[8'h40]);
    chk("ram41", 8'h22, far.ram[8'h41]);
    chk("ram50", 8'h33, far.ram[8'h50]);
    chk("ram51", 8'h44, far.ram[8'h51]);
    rdc("rxcnta", OFF_RX_CNT_A, 32'h2);
    rdc("rxcntb", OFF_RX_CNT_B, 32'h2);
    $display("test rx done");
  endtask
  task automatic t_cnt_load;
    wr(OFF_FLAG, 32'hF);
    wr(OFF_RX_CNT_A, 32'h1);
    wr(OFF_CTRL, 32'h0);
    rdc("ctrl", OFF_CTRL, 32'h1);
    far.rx_q.push_back(8'h5A);
    wait_flag(4'h1);
    chk("ram41", 8'h5A, far.ram[8'h41]);
    rdc("rxcnta", OFF_RX_CNT_A, 32'h2);
    $display("test count load done");
  endtask
  task automatic t_irq_early;
    wr(OFF_EN, 32'h0);
    #1 chk("masked", 1'b0, serial_top_irq);
    wr(OFF_EN, 32'h1);
    #1 chk("irq", 1'b1, serial_top_irq);
    rdc("en", OFF_EN, 32'h1);
    wr(OFF_FLAG, 32'h1);
    #1 chk("cleared", 1'b0, serial_top_irq);
    wr(OFF_RX_END_A, 32'h4F);
    wr(OFF_CTRL, 32'h1);
    rdc("stat", OFF_STAT, 32'h1);
    wr(OFF_RX_END_A, 32'h3F);
    rdc("stat", OFF_STAT, 32'h0);
    chk("early irq", 1'b1, serial_top_irq);
    wr(OFF_RX_CNT_B, 32'h1);
    rdc("ctrl", OFF_CTRL, 32'h2);
    wr(OFF_CTRL, 32'h10);
    rdc("ctrl", OFF_CTRL, 32'h0);
    rdc("rxcntb", OFF_RX_CNT_B, 32'h0);
    rdc("txcnt", OFF_TX_CNT, 32'h1);
    wr(OFF_CTRL, 32'h20);
    rdc("txcnt", OFF_TX_CNT, 32'h0);
    $display("test irq and early unload done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Whole run takes under two hundred cycles
  initial begin
    #(20000 * 100);
    errors++;
    conclude();
  end
  initial begin
    errors = 0; check_count = 0;
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; tx_stall = 1'b1;
    reg_addr = 8'h00; reg_wdata = 32'h0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_cnt_load();
    t_irq_early();
    conclude();
  end
endmodule
